//--- hdl/btc_capture.sv
// Purpose: Oversample processor bus strobes and log each read word and write
// Assumes: Strobes are asynchronous; bus stable around strobe edges
// Notes: Data paths taken from the 3-stage pipe aligned with strobes
`timescale 1ns/100ps
`include "btc_params.svh"
module btc_capture
   import btc_pkg::*;
#(
   parameter int DEPTH = `BTC_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Processor bus pins
   input wire logic i_read_n,
   input wire logic i_write_n,
   input wire logic i_read_data_enable_n,
   input wire logic [`BTC_ADDR_W-1:0] i_addr,
   input wire logic [`BTC_DATA_W-1:0] i_ad,
   input wire logic i_diag_1,
   input wire logic i_diag_0,
   // Trace store side
   output btc_rec_t o_rec,
   output logic o_rec_valid,
   input wire logic i_rec_ready,
   // Status
   output logic o_overflow
);
   // ============================================================
   // Input synchronisers
   // ============================================================
   // All pins share one pipe so data stays aligned with its strobe
   localparam int SW = 3 + 2 + `BTC_ADDR_W + `BTC_DATA_W;
   logic [SW-1:0] s1_q;
   logic [SW-1:0] s2_q;
   logic [SW-1:0] s3_q;
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
      end else begin
         s1_q <= {i_read_n, i_write_n, i_read_data_enable_n, i_diag_1, i_diag_0, i_addr, i_ad};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   logic rd_n2, wr_n2, rde_n2, rd_n3, wr_n3, rde_n3;
   logic a2_2, a2_3;
   assign {rd_n2, wr_n2, rde_n2} = s2_q[SW-1 -: 3];
   assign {rd_n3, wr_n3, rde_n3} = s3_q[SW-1 -: 3];
   assign a2_2 = s2_q[`BTC_DATA_W + 2];
   assign a2_3 = s3_q[`BTC_DATA_W + 2];
   logic diag_1_s, diag_0_s;
   assign diag_1_s = s3_q[`BTC_ADDR_W + `BTC_DATA_W + 1];
   assign diag_0_s = s3_q[`BTC_ADDR_W + `BTC_DATA_W];

   // ============================================================
   // Helper functions
   // ============================================================
   // Filtered move to a level: stages agree and differ from held level
   function automatic logic settled_to(input logic s2, input logic s3, input logic lvl, input logic prev);
      return (s2 == s3) && (s2 == lvl) && (prev != lvl);
   endfunction

   // Status nibble from diagnostic pins and trigger kind
   function automatic btc_status_t status_of(input logic diag_1, input logic diag_0, input logic wr,
      input logic ps);
      btc_status_t st;
      st.is_write = wr;
      st.cached = diag_1;
      // Fetch flag only meaningful on cacheable reads
      st.ifetch = diag_1 && diag_0 && !wr;
      st.pseudo = ps && !wr;
      return st;
   endfunction

   // ============================================================
   // Filtered strobe levels and edges
   // ============================================================
   logic rd_n_q, wr_n_q, rde_n_q, a2_q;
   logic rde_fall, rde_rise, wr_rise, a2_tog;
   assign rde_fall = settled_to(rde_n2, rde_n3, 1'b0, rde_n_q);
   assign rde_rise = settled_to(rde_n2, rde_n3, 1'b1, rde_n_q);
   assign wr_rise = settled_to(wr_n2, wr_n3, 1'b1, wr_n_q);
   assign a2_tog = (a2_2 == a2_3) && (a2_2 != a2_q);
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         rde_n_q <= 1'b1;
         a2_q <= 1'b1; // Matches synchroniser reset level
      end else begin
         if (rd_n2 == rd_n3) rd_n_q <= rd_n2;
         if (wr_n2 == wr_n3) wr_n_q <= wr_n2;
         if (rde_n2 == rde_n3) rde_n_q <= rde_n2;
         if (a2_2 == a2_3) a2_q <= a2_2;
      end
   end

   // ============================================================
   // Cycle tracking
   // ============================================================
   // Read or write cycle in progress, from filtered strobe levels
   btc_state_t state_q;
   logic rde_word_q;
   logic held_q;
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_q <= BTC_IDLE;
      end else begin
         case (state_q)
            BTC_IDLE: begin
               if (!wr_n_q) state_q <= BTC_WRITE;
               else if (!rd_n_q) state_q <= BTC_READ;
            end
            BTC_READ: begin
               if (rd_n_q) state_q <= BTC_IDLE;
            end
            BTC_WRITE: begin
               if (wr_n_q) state_q <= BTC_IDLE;
            end
            default: state_q <= BTC_IDLE;
         endcase
      end
   end
   // Read-data-enable held through several words
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         held_q <= 1'b0;
      end else if (rde_fall || rde_rise) begin
         held_q <= 1'b0;
      end else if (!rde_n_q && !rd_n_q && a2_tog) begin
         held_q <= 1'b1;
      end
   end
   assign rde_word_q = held_q;

   // ============================================================
   // Trigger decode
   // ============================================================
   logic load_trig, pseudo_trig, store_trig;
   // Strobe edges and word address toggles sample; no bus clock or acknowledge qualify here
   // A read-data-enable edge inside a write cycle is a false trigger
   assign load_trig = rde_fall && wr_n_q && !rd_n_q && (state_q == BTC_READ);
   // Emulated strobe: word address moved while enable stays low
   // Without it only the first word of a held-enable burst lands
   assign pseudo_trig = !rde_n_q && !rd_n_q && wr_n_q && a2_tog && (state_q == BTC_READ);
   assign store_trig = wr_rise;

   // ============================================================
   // Record build
   // ============================================================
   btc_rec_t rec_d;
   logic rec_v_d;
   always_comb begin
      rec_d = '0;
      rec_v_d = 1'b0;
      rec_d.addr = s3_q[`BTC_DATA_W +: `BTC_ADDR_W];
      rec_d.data = s3_q[`BTC_DATA_W-1:0];
      rec_d.status = status_of(diag_1_s, diag_0_s, 1'b0, 1'b0);
      if (store_trig) begin
         // Write strobe rise: record is a store
         rec_d.status = status_of(diag_1_s, diag_0_s, 1'b1, 1'b0);
         rec_v_d = 1'b1;
      end else if (load_trig || pseudo_trig) begin
         // Real or emulated read-data-enable edge: record is a load
         rec_d.status = status_of(diag_1_s, diag_0_s, 1'b0, pseudo_trig || rde_word_q);
         rec_v_d = 1'b1;
      end
   end

   // ============================================================
   // Trace buffer
   // ============================================================
   logic f_ready;
   btc_rec_t f_out;
   logic f_valid;
   // Records queue so a slow sink never stalls the processor
   // FIFO pops only while the output stage is empty
   btc_fifo #(.WIDTH(`BTC_REC_W), .DEPTH(DEPTH)) btc_fifo_inst (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_in_valid(rec_v_d),
      .i_in_data(rec_d),
      .o_in_ready(f_ready),
      .o_out_valid(f_valid),
      .o_out_data(f_out),
      .i_out_ready(i_rec_ready && !o_rec_valid)
   );
   // Output register: one record staged at a time
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_rec_valid <= 1'b0;
         o_rec <= '0;
      end else if (o_rec_valid) begin
         if (i_rec_ready) o_rec_valid <= 1'b0;
      end else if (f_valid && i_rec_ready) begin
         o_rec_valid <= 1'b1;
         o_rec <= f_out;
      end
   end
   // Sticky loss flag: capture cannot stall the processor
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_overflow <= 1'b0;
      end else if (rec_v_d && !f_ready) begin
         o_overflow <= 1'b1;
      end
   end
endmodule

//--- hdl/btc_params.svh
// Purpose: Constants for the bus trace capture block
// Assumes: 200 MHz core clock
// Notes: Included by package and modules
`ifndef BTC_PARAMS_SVH
`define BTC_PARAMS_SVH
`define BTC_ADDR_W 32
`define BTC_DATA_W 32
`define BTC_FIFO_DEPTH 32
`define BTC_REC_W 68
`define BTC_ST_WRITE 3
`define BTC_ST_CACHED 2
`define BTC_ST_IFETCH 1
`define BTC_ST_PSEUDO 0
`endif

//--- hdl/btc_pkg.sv
// Purpose: Types for the bus trace capture block
// Assumes: Params header present
// Notes: Record is the FIFO word
`include "btc_params.svh"
package btc_pkg;
   typedef struct packed {
      logic is_write;
      logic cached;
      logic ifetch;
      logic pseudo;
   } btc_status_t;
   typedef struct packed {
      logic [`BTC_ADDR_W-1:0] addr;
      logic [`BTC_DATA_W-1:0] data;
      btc_status_t status;
   } btc_rec_t;
   typedef enum logic [2:0] {
      BTC_IDLE = 3'h1,
      BTC_READ = 3'h2,
      BTC_WRITE = 3'h4
   } btc_state_t;
endpackage

//--- hdl/btc_fifo.sv
// Purpose: Synchronous FIFO for trace records
// Assumes: Single clock, sync active-high reset
// Notes: Depth is a power of two
`timescale 1ns/100ps
module btc_fifo #(
   parameter int WIDTH = 68,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;
   assign o_in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign o_out_valid = wr_q != rd_q;
   assign o_out_data = mem[rd_q[AW-1:0]];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= i_in_data;
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_q <= '0;
      end else if (push) begin
         wr_q <= wr_q + 1'b1;
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rd_q <= '0;
      end else if (pop) begin
         rd_q <= rd_q + 1'b1;
      end
   end
endmodule

//--- testbench/btc_capture_props.sv
// Purpose: Port checks for bus trace capture
// Assumes: Pins hold each level 4 clocks
// Notes: Bound into btc_capture
`timescale 1ns/100ps
module btc_capture_props
   import btc_pkg::*;
(
   // Watched ports
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_read_n,
   input wire logic i_write_n,
   input wire logic i_read_data_enable_n,
   input wire btc_rec_t o_rec,
   input wire logic o_rec_valid,
   input wire logic i_rec_ready,
   input wire logic o_overflow
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // ====================
   // Assertions
   property p_rst; $fell(i_rst) |-> !o_rec_valid && !o_overflow; endproperty
   a_rst: assert property (p_rst) else $error("outputs set after reset");
   property p_load;
      $fell(i_read_data_enable_n) && !i_read_n && i_write_n && i_rec_ready |-> ##[1:8] o_rec_valid;
   endproperty
   a_load: assert property (p_load) else $error("load not recorded");
   property p_store; $rose(i_write_n) && i_rec_ready |-> ##[1:8] o_rec_valid; endproperty
   a_store: assert property (p_store) else $error("store not recorded");
   property p_hold; o_rec_valid && !i_rec_ready |=> o_rec_valid && $stable(o_rec); endproperty
   a_hold: assert property (p_hold) else $error("record dropped while stalled");
   property p_gap; o_rec_valid && i_rec_ready |=> !o_rec_valid; endproperty
   a_gap: assert property (p_gap) else $error("no gap after handover");
   property p_ovf; o_overflow |=> o_overflow; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag cleared");
   property p_fetch; o_rec_valid && o_rec.status.ifetch |-> o_rec.status.cached; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch without cached");
   property p_wr; o_rec_valid && o_rec.status.is_write |-> !o_rec.status.pseudo; endproperty
   a_wr: assert property (p_wr) else $error("pseudo write record");
   c_wr: cover property (o_rec_valid && o_rec.status.is_write);
   c_ps: cover property (o_rec_valid && o_rec.status.pseudo);
   c_ovf: cover property ($rose(o_overflow));
endmodule
bind btc_capture btc_capture_props btc_capture_props_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_read_n(i_read_n), .i_write_n(i_write_n), .i_read_data_enable_n(i_read_data_enable_n),
   .o_rec(o_rec), .o_rec_valid(o_rec_valid), .i_rec_ready(i_rec_ready), .o_overflow(o_overflow));

//--- testbench/btc_cpu_model.sv
// Purpose: Processor local bus model
// Assumes: Each pin level held 4 clocks
// Notes: Released bus shows inverse of last value
`timescale 1ns/100ps
`include "btc_params.svh"
module btc_cpu_model (
   // Clock
   input wire logic i_core_clk,
   // Bus pins
   output logic o_read_n = 1'b1,
   output logic o_write_n = 1'b1,
   output logic o_read_data_enable_n = 1'b1,
   output logic [`BTC_ADDR_W-1:0] o_addr = 32'h0,
   output logic [`BTC_DATA_W-1:0] o_ad = 32'h0,
   output logic o_diag_1 = 1'b0,
   output logic o_diag_0 = 1'b0
);
   task automatic hold(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task automatic cpu_read(input logic [31:0] a, input logic [31:0] d, input logic [1:0] dg, input bit tog);
      @(posedge i_core_clk);
      o_read_n <= 1'b0;
      {o_diag_1, o_diag_0} <= dg;
      o_addr <= a;
      hold(4);
      for (int i = 0; i < 4; i++) begin
         o_addr <= a + 32'(4 * i);
         o_ad <= d + 32'(i);
         o_read_data_enable_n <= 1'b0;
         hold(4);
         if (tog) begin
            o_read_data_enable_n <= 1'b1;
            hold(4);
         end
      end
      o_read_n <= 1'b1;
      o_read_data_enable_n <= 1'b1;
      o_ad <= ~o_ad;
      hold(4);
   endtask
   task automatic cpu_write(input logic [31:0] a, input bit rde);
      @(posedge i_core_clk);
      o_write_n <= 1'b0;
      o_read_data_enable_n <= !rde;
      {o_diag_1, o_diag_0} <= 2'h0;
      o_addr <= a;
      o_ad <= a;
      hold(4);
      o_write_n <= 1'b1;
      o_read_data_enable_n <= 1'b1;
      hold(4);
      o_ad <= ~o_ad;
   endtask
endmodule

//--- testbench/btc_capture_bench.sv
// Purpose: Scenario bench for bus trace capture
// Assumes: Small FIFO depth
// Notes: Collector queues every handed-over record
`timescale 1ns/100ps
module btc_capture_bench
   import btc_pkg::*;
   ;
   localparam int DEPTH = 4;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_rec_ready = 1'b1;
   wire logic rd_n, wr_n, rde_n, dg1, dg0;
   wire logic [31:0] addr, ad;
   btc_rec_t o_rec;
   logic o_rec_valid, o_overflow;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   btc_rec_t got_q[$];
   btc_cpu_model btc_cpu_model_inst (.i_core_clk(i_core_clk), .o_read_n(rd_n), .o_write_n(wr_n),
      .o_read_data_enable_n(rde_n), .o_addr(addr), .o_ad(ad), .o_diag_1(dg1), .o_diag_0(dg0));
   btc_capture #(.DEPTH(DEPTH)) btc_capture_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_read_n(rd_n),
      .i_write_n(wr_n), .i_read_data_enable_n(rde_n), .i_addr(addr), .i_ad(ad), .i_diag_1(dg1),
      .i_diag_0(dg0), .o_rec(o_rec), .o_rec_valid(o_rec_valid), .i_rec_ready(i_rec_ready),
      .o_overflow(o_overflow));
   initial begin
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   // ====================
   // Helpers
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (o_rec_valid === 1'b1 && i_rec_ready === 1'b1) got_q.push_back(o_rec);
      if (cycles == 3000) begin
         failures = failures + 1;
         finish_test();
      end
   end
   task automatic wait_n(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task automatic check(input string nm, input logic [67:0] got, input logic [67:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic take(input string nm, input btc_rec_t exp);
      btc_rec_t r;
      r = 'x;
      if (got_q.size() > 0) r = got_q.pop_front();
      check(nm, r, exp);
   endtask
   // ====================
   // Scenarios
   task automatic t_burst();
      btc_cpu_model_inst.cpu_read(32'h1000, 32'ha0000000, 2'h3, 1'b1);
      wait_n(20);
      for (int i = 0; i < 4; i++) take("burst", {32'h1000 + 32'(4 * i), 32'ha0000000 + 32'(i), 4'h6});
      check("burst count", 68'(got_q.size()), 68'h0);
      $display("test burst done");
   endtask
   task automatic t_write();
      btc_cpu_model_inst.cpu_write(32'h2000, 1'b1);
      wait_n(20);
      take("write", {32'h2000, 32'h2000, 4'h8});
      check("write count", 68'(got_q.size()), 68'h0);
      $display("test write done");
   endtask
   task automatic t_pseudo();
      btc_cpu_model_inst.cpu_read(32'h3000, 32'hc0000000, 2'h2, 1'b0);
      wait_n(20);
      take("pseudo first", {32'h3000, 32'hc0000000, 4'h4});
      for (int i = 1; i < 4; i++) take("pseudo", {32'h3000 + 32'(4 * i), 32'hc0000000 + 32'(i), 4'h5});
      $display("test pseudo done");
   endtask
   task automatic t_ovf();
      i_rec_ready <= 1'b0;
      for (int i = 0; i < 8; i++) btc_cpu_model_inst.cpu_write(32'h4000 + 32'(i), 1'b0);
      wait_n(10);
      check("overflow", 68'(o_overflow), 68'h1);
      i_rec_ready <= 1'b1;
      wait_n(1);
      i_rec_ready <= 1'b0;
      wait_n(5);
      check("stall valid", 68'(o_rec_valid), 68'h1);
      check("stall record", o_rec, {32'h4000, 32'h4000, 4'h8});
      i_rec_ready <= 1'b1;
      wait_n(40);
      check("drained", 68'(got_q.size() == DEPTH), 68'h1);
      take("order", {32'h4000, 32'h4000, 4'h8});
      got_q.delete();
      i_rst <= 1'b1;
      wait_n(4);
      i_rst <= 1'b0;
      wait_n(2);
      check("overflow reset", 68'(o_overflow), 68'h0);
      $display("test overflow done");
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      wait_n(12);
      i_rst <= 1'b0;
      wait_n(4);
      t_burst();
      t_write();
      t_pseudo();
      t_ovf();
      finish_test();
   end
endmodule
